// *** logic/stepper_pkg.sv ***
// Shared constants for the step-and-direction phase sequencer link.
// Assumes a single 125 MHz system clock on both ends.
package stepper_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int CLEAR_MIN_NS  = 10000;
   localparam int PULSE_MIN_NS  = 10000;
   localparam int DIR_HOLD_NS   = 6250;
   localparam int MODE_HOLD_NS  = 5000;
   localparam int CLEAR_CYC =
      (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC =
      (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIR_HOLD_CYC =
      (DIR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MODE_HOLD_CYC =
      (MODE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   // ----------------------------------------
   // Excitation index and phases
   // ----------------------------------------
   localparam logic [2:0] INIT_INDEX = 3'h0;
   localparam logic [3:0] PHASE_OFF  = 4'h0;
   // Phase bit order: {coil_two_neg, coil_two_pos, coil_one_neg, coil_one_pos}
   // Even index one coil half, odd index a pair; never both halves of a coil
   localparam logic [3:0] PHASE_TABLE [8] = '{
      4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9};

   // ----------------------------------------
   // Host register map (AHB-Lite byte offsets)
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STEPS  = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_DIR     = 1;
   localparam int CTRL_HALF    = 2;
   localparam int CTRL_RISE    = 3;
   localparam int CTRL_RUN     = 4;
   localparam int CTRL_PERIOD  = 16;
   localparam logic [15:0] PERIOD_RESET = 16'h0500;

   typedef enum {H_CLEAR, H_IDLE, H_HIGH, H_LOW} host_state_type;
endpackage : stepper_pkg

// *** logic/stepper_link.sv ***
// Link between host step controller and phase sequencer.
// Both ends share hclk and hresetn; all wires are plain levels.
`timescale 1ns/1ps
interface stepper_link;
   logic       system_clear_low;
   logic       step_clock;
   logic       rotation_direction;
   logic       excitation_select;
   logic       step_edge_select;
   logic       output_enable;
   logic [3:0] phases;

   modport host (
      output system_clear_low, step_clock, rotation_direction,
             excitation_select, step_edge_select, output_enable,
      input  phases
   );
   modport device (
      input  system_clear_low, step_clock, rotation_direction,
             excitation_select, step_edge_select, output_enable,
      output phases
   );
endinterface : stepper_link

// *** logic/edge_detect.sv ***
// Edge detector on a level already synchronous to hclk.
// Assumes the input was sampled by a flip-flop upstream.
`timescale 1ns/1ps
module edge_detect (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);
   logic last_ff;
   logic nxt_last;

   always_comb begin
      nxt_last = level;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_ff <= 1'b0;
      end else begin
         last_ff <= nxt_last;
      end
   end

   assign rise = level & ~last_ff;
   assign fall = ~level & last_ff;
endmodule : edge_detect

// *** logic/phase_sequencer.sv ***
// Device end: excitation state machine driving four coil phases.
// Assumes link inputs are synchronous to hclk and the host keeps
// its timing obligations.
`timescale 1ns/1ps
module phase_sequencer (
   input  wire logic   hclk,
   input  wire logic   hresetn,
   stepper_link.device link
);
   logic [2:0] index_ff;
   logic [2:0] nxt_index;
   logic [3:0] phases_ff;
   logic [3:0] nxt_phases;
   logic       clk_rise;
   logic       clk_fall;
   logic       advance;
   logic [2:0] stride;

   edge_detect u_edge (
      .hclk    (hclk),
      .hresetn (hresetn),
      .level   (link.step_clock),
      .rise    (clk_rise),
      .fall    (clk_fall)
   );

   // ----------------------------------------
   // Excitation index
   // ----------------------------------------
   always_comb begin
      // Rising always counts; falling only when edge select is low
      advance = clk_rise | (clk_fall & ~link.step_edge_select);
      // Two-phase steps by two through odd (pair) states
      stride = link.excitation_select ? 3'h1 : 3'h2;
      nxt_index = index_ff;
      if (!link.system_clear_low) begin
         nxt_index = stepper_pkg::INIT_INDEX;
      end else if (advance) begin
         if (link.rotation_direction) begin
            nxt_index = index_ff - stride;
         end else begin
            nxt_index = index_ff + stride;
         end
         // Switching to two-phase from a single state snaps to a pair
         if (!link.excitation_select && !index_ff[0]) begin
            nxt_index = link.rotation_direction ? index_ff - 3'h1
                                                : index_ff + 3'h1;
         end
      end
   end

   // ----------------------------------------
   // Phase outputs, registered
   // ----------------------------------------
   always_comb begin
      // Enable gates outputs only; index keeps running underneath
      if (!link.system_clear_low || !link.output_enable) begin
         nxt_phases = stepper_pkg::PHASE_OFF;
      end else begin
         nxt_phases = stepper_pkg::PHASE_TABLE[nxt_index];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         index_ff  <= stepper_pkg::INIT_INDEX;
         phases_ff <= stepper_pkg::PHASE_OFF;
      end else begin
         index_ff  <= nxt_index;
         phases_ff <= nxt_phases;
      end
   end

   assign link.phases = phases_ff;
endmodule : phase_sequencer

// *** logic/step_host.sv ***
// Host end: AHB-Lite slave registers and step pulse generator.
// Assumes a single AHB-Lite master; all transfers are whole words.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module step_host (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   stepper_link.host        link
);
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [15:0] steps_ff, nxt_steps;
   logic [7:0]  addr_ff, nxt_addr;
   logic        wr_ff, nxt_wr;
   logic [31:0] rdata_ff, nxt_rdata;
   stepper_pkg::host_state_type state_ff, nxt_state;
   logic [15:0] cnt_ff, nxt_cnt;
   logic        clk_ff, nxt_clk;
   logic        clr_ff, nxt_clr;
   logic [15:0] half;
   logic        take;
   logic [2:0]  lvl_ff;
   logic [2:0]  nxt_lvl;
   logic [2:0]  want;

   // ----------------------------------------
   // Bus slave: zero wait states
   // ----------------------------------------
   always_comb begin
      // Whole-word transfers only; other sizes are ignored
      take      = hsel & hready & htrans[1] & (hsize == 3'h2);
      nxt_wr    = take & hwrite;
      nxt_addr  = haddr;
      nxt_ctrl  = ctrl_ff;
      nxt_rdata = 32'h0000_0000;
      if (wr_ff && addr_ff == stepper_pkg::REG_CTRL) begin
         nxt_ctrl = hwdata;
      end
      if (take && !hwrite) begin
         unique case (haddr)
            stepper_pkg::REG_CTRL:   nxt_rdata = ctrl_ff;
            stepper_pkg::REG_STEPS:  nxt_rdata = {16'h0000, steps_ff};
            stepper_pkg::REG_STATUS: nxt_rdata = {27'h0, link.phases,
                                                  clr_ff};
            default:                 nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // Step generator
   // ----------------------------------------
   always_comb begin
      // Half period never below the minimum pulse width
      half = ctrl_ff[31:stepper_pkg::CTRL_PERIOD];
      if (half < 16'(stepper_pkg::PULSE_CYC)) begin
         half = 16'(stepper_pkg::PULSE_CYC);
      end
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 16'h0001;
      nxt_clk   = clk_ff;
      nxt_clr   = clr_ff;
      nxt_steps = steps_ff;
      nxt_lvl   = lvl_ff;
      want      = {ctrl_ff[stepper_pkg::CTRL_DIR],
                   ctrl_ff[stepper_pkg::CTRL_HALF],
                   ctrl_ff[stepper_pkg::CTRL_RISE]};
      if (wr_ff && addr_ff == stepper_pkg::REG_STEPS) begin
         nxt_steps = hwdata[15:0];
      end
      unique case (state_ff)
         stepper_pkg::H_CLEAR: begin
            if (cnt_ff >= 16'(stepper_pkg::CLEAR_CYC)) begin
               nxt_clr   = 1'b1;
               nxt_cnt   = 16'h0000;
               nxt_state = stepper_pkg::H_IDLE;
            end
         end
         stepper_pkg::H_IDLE: begin
            // Levels move only here, then rest a hold time before a rise;
            // the direction hold is the longer one, so it covers mode too
            if (lvl_ff != want) begin
               nxt_lvl = want;
               nxt_cnt = 16'h0000;
            end else if (cnt_ff >= 16'(stepper_pkg::DIR_HOLD_CYC)) begin
               nxt_cnt = cnt_ff;
               if (ctrl_ff[stepper_pkg::CTRL_RUN]
                   && steps_ff != 16'h0000) begin
                  nxt_state = stepper_pkg::H_HIGH;
                  nxt_clk   = 1'b1;
                  nxt_cnt   = 16'h0000;
               end
            end
         end
         stepper_pkg::H_HIGH: begin
            if (cnt_ff >= half) begin
               nxt_clk   = 1'b0;
               nxt_cnt   = 16'h0000;
               nxt_steps = steps_ff - 16'h0001;
               nxt_state = stepper_pkg::H_LOW;
            end
         end
         stepper_pkg::H_LOW: begin
            if (cnt_ff >= half) begin
               // Levels unchanged since before the rise: no fresh wait
               nxt_cnt   = 16'(stepper_pkg::DIR_HOLD_CYC);
               // Software ramps period field to slow down before stop
               nxt_state = stepper_pkg::H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff  <= {stepper_pkg::PERIOD_RESET, 16'h0001};
         steps_ff <= 16'h0000;
         addr_ff  <= 8'h00;
         wr_ff    <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         state_ff <= stepper_pkg::H_CLEAR;
         cnt_ff   <= 16'h0000;
         clk_ff   <= 1'b0;
         clr_ff   <= 1'b0;
         lvl_ff   <= 3'h0;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         steps_ff <= nxt_steps;
         addr_ff  <= nxt_addr;
         wr_ff    <= nxt_wr;
         rdata_ff <= nxt_rdata;
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         clk_ff   <= nxt_clk;
         clr_ff   <= nxt_clr;
         lvl_ff   <= nxt_lvl;
      end
   end

   assign hrdata    = rdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign link.system_clear_low   = clr_ff;
   assign link.step_clock         = clk_ff;
   assign link.output_enable      = ctrl_ff[stepper_pkg::CTRL_ENABLE];
   assign link.rotation_direction = lvl_ff[2];
   assign link.excitation_select  = lvl_ff[1];
   assign link.step_edge_select   = lvl_ff[0];
endmodule : step_host

// *** verif/stepper_link_props.sv ***
// Concurrent checks on the link between host and sequencer.
// Assumes link levels are synchronous to hclk; phases lag edges by 1.
`timescale 1ns/1ps
module stepper_link_props (
   input logic       hclk,
   input logic       hresetn,
   input logic       system_clear_low,
   input logic       step_clock,
   input logic       rotation_direction,
   input logic       excitation_select,
   input logic       step_edge_select,
   input logic       output_enable,
   input logic [3:0] phases
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // Output cut-off and coil safety
   // ----------------------------------------
   clear_cuts_a: assert property (
      !system_clear_low |=> phases == 4'h0) else $error("on in clear");
   enable_cuts_a: assert property (
      !output_enable |=> phases == 4'h0) else $error("on while off");
   coil_safe_a: assert property (
      !(&phases[1:0]) && !(&phases[3:2])) else $error("coil shorted");
   // ----------------------------------------
   // Stepping; enable checked a cycle back too, except in fall_ignored_a
   // ----------------------------------------
   hold_still_a: assert property (
      ($stable(step_clock) && system_clear_low && output_enable)[*3]
      |-> $stable(phases)) else $error("moved without edge");
   rise_moves_a: assert property (
      $rose(step_clock) && system_clear_low && $past(output_enable)
      && output_enable |-> ##2 phases != $past(phases, 2))
      else $error("rise ignored");
   fall_moves_a: assert property (
      $fell(step_clock) && !step_edge_select && system_clear_low
      && $past(output_enable) && output_enable
      |-> ##2 phases != $past(phases, 2)) else $error("fall ignored");
   fall_ignored_a: assert property (
      $fell(step_clock) && step_edge_select && output_enable
      |-> ##2 phases == $past(phases, 2)) else $error("fall stepped");
   pair_only_a: assert property (
      $rose(step_clock) && !excitation_select && system_clear_low
      && $past(output_enable) && output_enable
      |-> ##2 $countones(phases) == 2) else $error("not a pair");
   half_alt_a: assert property (
      $rose(step_clock) && excitation_select && system_clear_low
      && $past(output_enable) && output_enable
      |-> ##2 $countones(phases) != $countones($past(phases, 2)))
      else $error("half step not alternating");
   // ----------------------------------------
   // Host timing; counters saturate so a long rest reads as far
   // ----------------------------------------
   logic        clk_q_ff;
   logic        nxt_clk_q;
   logic        dir_q_ff;
   logic        nxt_dir_q;
   logic [1:0]  mode_q_ff;
   logic [1:0]  nxt_mode_q;
   logic [15:0] since_clk_ff;
   logic [15:0] nxt_since_clk;
   logic [15:0] since_rise_ff;
   logic [15:0] nxt_since_rise;
   logic [15:0] since_dir_ff;
   logic [15:0] nxt_since_dir;
   logic [15:0] since_mode_ff;
   logic [15:0] nxt_since_mode;

   function automatic logic [15:0] bump(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : bump

   always_comb begin
      nxt_clk_q      = step_clock;
      nxt_dir_q      = rotation_direction;
      nxt_mode_q     = {excitation_select, step_edge_select};
      nxt_since_clk  = (step_clock != clk_q_ff) ? 16'h0001
                                                : bump(since_clk_ff);
      nxt_since_rise = (step_clock && !clk_q_ff) ? 16'h0001
                                                 : bump(since_rise_ff);
      nxt_since_dir  = (rotation_direction != dir_q_ff) ? 16'h0001
                                                        : bump(since_dir_ff);
      nxt_since_mode = (nxt_mode_q != mode_q_ff) ? 16'h0001
                                                 : bump(since_mode_ff);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_q_ff      <= 1'b0;
         dir_q_ff      <= 1'b0;
         mode_q_ff     <= 2'h0;
         since_clk_ff  <= 16'hFFFF;
         since_rise_ff <= 16'hFFFF;
         since_dir_ff  <= 16'hFFFF;
         since_mode_ff <= 16'hFFFF;
      end else begin
         clk_q_ff      <= nxt_clk_q;
         dir_q_ff      <= nxt_dir_q;
         mode_q_ff     <= nxt_mode_q;
         since_clk_ff  <= nxt_since_clk;
         since_rise_ff <= nxt_since_rise;
         since_dir_ff  <= nxt_since_dir;
         since_mode_ff <= nxt_since_mode;
      end
   end

   pulse_wide_a: assert property (
      $changed(step_clock)
      |-> since_clk_ff >= 16'(stepper_pkg::PULSE_CYC))
      else $error("step pulse too short");
   dir_setup_a: assert property (
      $rose(step_clock) |-> $stable(rotation_direction)
      && since_dir_ff >= 16'(stepper_pkg::DIR_HOLD_CYC))
      else $error("direction moved before rise");
   dir_hold_a: assert property (
      $changed(rotation_direction)
      |-> since_rise_ff >= 16'(stepper_pkg::DIR_HOLD_CYC))
      else $error("direction moved after rise");
   mode_setup_a: assert property (
      $rose(step_clock) |-> $stable(excitation_select)
      && $stable(step_edge_select)
      && since_mode_ff >= 16'(stepper_pkg::MODE_HOLD_CYC))
      else $error("mode moved before rise");
   mode_hold_a: assert property (
      $changed(excitation_select) || $changed(step_edge_select)
      |-> since_rise_ff >= 16'(stepper_pkg::MODE_HOLD_CYC))
      else $error("mode moved after rise");
endmodule : stepper_link_props

// *** verif/stepper_phase_sequencer_tb.sv ***
// Bench: drives the host registers over AHB-Lite, watches the link.
// Assumes hreadyout answers every phase; waits are cut by a timeout.
`timescale 1ns/1ps
module stepper_phase_sequencer_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] rd;
   logic [3:0]  pair;
   int          miscompares;
   int          checked;
   int          cycles;
   stepper_link lnk ();
   step_host i_step_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link(lnk));
   phase_sequencer i_phase_sequencer (.hclk(hclk), .hresetn(hresetn),
      .link(lnk));
   stepper_link_props i_stepper_link_props (.hclk(hclk),
      .hresetn(hresetn), .system_clear_low(lnk.system_clear_low),
      .step_clock(lnk.step_clock), .excitation_select(lnk.excitation_select),
      .rotation_direction(lnk.rotation_direction),
      .step_edge_select(lnk.step_edge_select),
      .output_enable(lnk.output_enable), .phases(lnk.phases));
   // ----------------------------------------
   // Clock, timeout, checks
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic test_done;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Position n places along the half-step cycle from p
   function automatic logic [3:0] step_to(input logic [3:0] p, input int n);
      int k;
      k = 0;
      for (int i = 0; i < 8; i++)
         if (stepper_pkg::PHASE_TABLE[i] === p) k = i;
      return stepper_pkg::PHASE_TABLE[(k + n + 16) % 8];
   endfunction : step_to
   // ----------------------------------------
   // Bus access and stepping runs
   // ----------------------------------------
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : ahb
   // Control first: a count loaded under the old run bit would start
   // a pulse with stale levels. Tail covers the last low half period.
   task automatic run(input logic [31:0] c, input logic [15:0] n);
      ahb(1'b1, stepper_pkg::REG_CTRL, c, rd);
      ahb(1'b1, stepper_pkg::REG_STEPS, {16'h0000, n}, rd);
      do ahb(1'b0, stepper_pkg::REG_STEPS, 32'h0, rd);
      while (rd[15:0] !== 16'h0000);
      repeat (1300) @(posedge hclk);
   endtask : run
   task automatic chk_ph(input logic [3:0] e);
      chk({28'h0000000, lnk.phases}, {28'h0000000, e});
   endtask : chk_ph
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      miscompares = 0;
      checked = 0;
      cycles = 0;
      repeat (4) @(posedge hclk);
      chk_ph(4'h0);
      hresetn <= 1'b1;
      repeat (stepper_pkg::CLEAR_CYC - 10) @(posedge hclk);
      chk_ph(4'h0);
      chk({31'h0, lnk.system_clear_low}, 32'h00000000);
      repeat (20) @(posedge hclk);
      ahb(1'b0, stepper_pkg::REG_STATUS, 32'h0, rd);
      chk({27'h0, rd[4:0]}, 32'h00000003);
      ahb(1'b0, stepper_pkg::REG_CTRL, 32'h0, rd);
      chk(rd, 32'h05000001);
      ahb(1'b0, 8'h0C, 32'h0, rd);
      chk(rd, 32'h00000000);
      // Control words: {period, run, rise, half, dir, enable}
      run(32'h0500001D, 16'h0001);
      chk_ph(step_to(4'h1, 1));
      run(32'h05000017, 16'h0001);
      chk_ph(step_to(4'h1, -1));
      run(32'h0500001C, 16'h0003);
      chk_ph(4'h0);
      ahb(1'b1, stepper_pkg::REG_CTRL, 32'h0500000D, rd);
      repeat (4) @(posedge hclk);
      chk_ph(step_to(4'h1, 2));
      run(32'h05000019, 16'h0001);
      pair = lnk.phases;
      chk(32'($countones(pair)), 32'h00000002);
      run(32'h05000019, 16'h0004);
      chk_ph(pair);
      test_done();
   end
endmodule : stepper_phase_sequencer_tb
